// ==== verilog/rp_attr_pkg.sv ====
// Shared types and constants of the root port attribute and access-control stage.
// Assumes one clock domain and a synchronous active-low reset.
package rp_attr_pkg;

  localparam int ADDR_W = 48;
  localparam int CNT_W  = 8;

  localparam logic [1:0] CACHE_NC = 2'h0;
  localparam logic [1:0] CACHE_WB = 2'h2;
  localparam logic [1:0] SH_OUTER = 2'h2;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_MAX  = 8'hff;

  typedef struct packed {
    logic       normal;
    logic [1:0] inner;
    logic [1:0] outer;
    logic [1:0] share;
    logic       alloc;
    logic       nomerge;
  } attr_s;

  // Normal, inner and outer write-back cacheable, outer shareable.
  localparam attr_s ATTR_INIT = '{normal: 1'b1, inner: CACHE_WB, outer: CACHE_WB,
                                  share: SH_OUTER, alloc: 1'b1, nomerge: 1'b0};
  // Strongly ordered, uncached, never merged, never allocating.
  localparam attr_s ATTR_DEV  = '{normal: 1'b0, inner: CACHE_NC, outer: CACHE_NC,
                                  share: SH_OUTER, alloc: 1'b0, nomerge: 1'b1};
  localparam attr_s ATTR_NC   = '{normal: 1'b1, inner: CACHE_NC, outer: CACHE_NC,
                                  share: SH_OUTER, alloc: 1'b0, nomerge: 1'b0};

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [15:0]       rid;
    logic [7:0]        tag;
    logic              write;
    logic              cpl;
    logic              io;
    logic              translated;
  } txn_s;

  typedef struct packed {
    logic v;
    logic b;
    logic r;
    logic c;
    logic u;
    logic t;
  } acs_ctl_s;

  typedef enum logic [2:0] {
    ERR_NONE,
    ERR_SRC,
    ERR_XLAT_BLK,
    ERR_PERM,
    ERR_NO_P2P
  } acs_err_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [15:0]       rid;
    attr_s             attr;
  } xreq_s;

  typedef struct packed {
    logic [ADDR_W-1:0] pa;
    attr_s             attr;
    logic              perm_ok;
  } xrsp_s;

  typedef struct packed {
    txn_s  txn;
    attr_s attr;
  } out_s;

  typedef struct packed {
    acs_err_e          code;
    logic [15:0]       rid;
    logic [ADDR_W-1:0] addr;
  } err_s;

endpackage

// ==== verilog/addr_window.sv ====
// Inclusive address window comparator.
// Assumes base and limit are static while traffic flows.
`timescale 1ns/1ns
module addr_window
(
  // Window
  input  wire logic [rp_attr_pkg::ADDR_W-1:0] base_in,
  input  wire logic [rp_attr_pkg::ADDR_W-1:0] limit_in,
  // Probe
  input  wire logic [rp_attr_pkg::ADDR_W-1:0] addr_in,
  output logic                                hit_out
);

  assign hit_out = (addr_in >= base_in) && (addr_in <= limit_in);

endmodule

// ==== verilog/acs_log.sv ====
// Violation log: sticky status, first-error header and a one-cycle report pulse.
// Assumes the error reporting block outside consumes the pulse and header.
`timescale 1ns/1ns
module acs_log
(
  // Clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rst_b_in,
  // Event
  input  wire logic              ev_in,
  input  wire rp_attr_pkg::err_s ev_hdr_in,
  input  wire logic              clr_in,
  // Report
  output logic                   status_out,
  output rp_attr_pkg::err_s      hdr_out,
  output logic                   report_out
);

  logic              status_q;
  logic              status_d;
  rp_attr_pkg::err_s hdr_q;
  rp_attr_pkg::err_s hdr_d;
  logic              report_q;

  always_comb
  begin
    // A new violation in the clearing cycle still sets the status.
    status_d = (status_q && !clr_in) || ev_in;
    hdr_d    = hdr_q;
    if (ev_in && (!status_q || clr_in))
    begin
      hdr_d = ev_hdr_in;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      status_q <= 1'b0;
      hdr_q    <= '0;
      report_q <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      hdr_q    <= hdr_d;
      report_q <= ev_in;
    end
  end

  assign status_out = status_q;
  assign hdr_out    = hdr_q;
  assign report_out = report_q;

endmodule

// ==== verilog/pcie_root_port_attr_acs.sv ====
// Root port stage that settles final memory attributes and enforces peer access control.
// Assumes inbound requests arrive one at a time on a valid/ready port and that the
// translation unit answers every query it accepts.
//
// Functional notes
// - Current attributes go to the translation unit with each query.
// - Attributes returned by the translation unit replace the transaction's attributes.
// - Selected address targets get overriding attributes from a configured special window.
// - Interrupt message writes wait until all earlier upstream writes have completed.
// - Interrupt message writes never merge and never allocate in caches.
// - Peer BAR targets keep uncached, unmerged, ordered device properties.
// - Without I/O coherency, no cacheable attributes leave the port except those of the special window.
// - Legacy I/O maps one-to-one onto a fixed physical window set before boot.
// - Unsupported peer requests are dropped and reported, never stalled.
// - Source validation and translation blocking are enforced.
// - Peer request redirect, completion redirect and upstream forwarding are enforced.
// - Redirected requests are validated through the translation unit.
// - Access violations are detected, logged and reported.
// - Traffic to other root ports is validated first, violations logged alike.
// - Direct translated peer traffic is supported when translation services exist.
// - Nothing is merged or altered before final attributes are settled.
// - Every inbound transaction starts write-back cacheable, outer shareable.
`timescale 1ns/1ns
module pcie_root_port_attr_acs
(
  // Clock and reset
  input  wire logic                                mclk_in,
  input  wire logic                                rst_b_in,
  // Inbound requests from the link
  input  wire logic                                in_valid_in,
  input  wire rp_attr_pkg::txn_s                   in_txn_in,
  output logic                                     in_ready_out,
  // Translation unit
  input  wire logic                                xlat_present_in,
  input  wire logic                                xlat_bypass_in,
  output logic                                     xq_valid_out,
  output rp_attr_pkg::xreq_s                       xq_out,
  input  wire logic                                xq_ready_in,
  input  wire logic                                xr_valid_in,
  input  wire rp_attr_pkg::xrsp_s                  xr_in,
  // Configuration
  input  wire rp_attr_pkg::acs_ctl_s               acs_ctl_in,
  input  wire logic                                p2p_en_in,
  input  wire logic                                peer_rp_en_in,
  input  wire logic                                ats_en_in,
  input  wire logic                                io_coherent_in,
  input  wire logic [7:0]                          sec_bus_in,
  input  wire logic [7:0]                          sub_bus_in,
  input  wire logic [rp_attr_pkg::ADDR_W-1:0]      io_win_base_in,
  input  wire logic [rp_attr_pkg::ADDR_W-1:0]      msi_base_in,
  input  wire logic [rp_attr_pkg::ADDR_W-1:0]      msi_limit_in,
  input  wire logic [rp_attr_pkg::ADDR_W-1:0]      peer_base_in,
  input  wire logic [rp_attr_pkg::ADDR_W-1:0]      peer_limit_in,
  input  wire logic [rp_attr_pkg::ADDR_W-1:0]      spec_base_in,
  input  wire logic [rp_attr_pkg::ADDR_W-1:0]      spec_limit_in,
  input  wire rp_attr_pkg::attr_s                  spec_attr_in,
  // Upstream to the memory interconnect
  output logic                                     up_valid_out,
  output rp_attr_pkg::out_s                        up_out,
  input  wire logic                                up_ready_in,
  input  wire logic                                wr_ack_in,
  // Egress to peer root ports
  output logic                                     peer_valid_out,
  output rp_attr_pkg::out_s                        peer_out,
  input  wire logic                                peer_ready_in,
  // Drops and violation reporting
  output logic                                     drop_out,
  input  wire logic                                err_clr_in,
  output logic                                     err_status_out,
  output rp_attr_pkg::err_s                        err_hdr_out,
  output logic                                     err_report_out
);

  // ***********************************************************************
  // State
  // ***********************************************************************

  typedef enum logic [2:0] {
    S_IDLE,
    S_CHECK,
    S_XREQ,
    S_XWAIT,
    S_OVR,
    S_DRAIN,
    S_ISSUE
  } state_e;

  state_e                          state_q;
  state_e                          state_d;
  rp_attr_pkg::txn_s               txn_q;
  rp_attr_pkg::txn_s               txn_d;
  rp_attr_pkg::attr_s              attr_q;
  rp_attr_pkg::attr_s              attr_d;
  logic                            peer_q;
  logic                            peer_d;
  logic                            val_q;
  logic                            val_d;
  logic                            msi_q;
  logic                            msi_d;
  logic                            drop_q;
  logic                            drop_d;
  logic [rp_attr_pkg::CNT_W-1:0]   cnt_q;
  logic [rp_attr_pkg::CNT_W-1:0]   cnt_d;

  logic                            err_v;
  rp_attr_pkg::acs_err_e           err_c;
  rp_attr_pkg::err_s               err_hdr;
  logic                            msi_hit;
  logic                            peer_hit;
  logic                            spec_hit;
  logic                            redirect;
  logic                            up_fire;
  logic                            peer_fire;
  logic                            inc;
  logic                            dec;

  // ***********************************************************************
  // Address windows
  // ***********************************************************************

  addr_window u_msi_win
  (
    .base_in  (msi_base_in),
    .limit_in (msi_limit_in),
    .addr_in  (txn_q.addr),
    .hit_out  (msi_hit)
  );

  addr_window u_peer_win
  (
    .base_in  (peer_base_in),
    .limit_in (peer_limit_in),
    .addr_in  (txn_q.addr),
    .hit_out  (peer_hit)
  );

  addr_window u_spec_win
  (
    .base_in  (spec_base_in),
    .limit_in (spec_limit_in),
    .addr_in  (txn_q.addr),
    .hit_out  (spec_hit)
  );

  // Peer requests go through validation when any redirect control asks for it.
  assign redirect = peer_hit && (acs_ctl_in.r || acs_ctl_in.u || peer_rp_en_in);

  // ***********************************************************************
  // Transaction sequencing
  // ***********************************************************************

  always_comb
  begin
    state_d = state_q;
    txn_d   = txn_q;
    attr_d  = attr_q;
    peer_d  = peer_q;
    val_d   = val_q;
    msi_d   = msi_q;
    drop_d  = 1'b0;
    err_v   = 1'b0;
    err_c   = rp_attr_pkg::ERR_NONE;
    case (state_q)
      S_IDLE:
      begin
        if (in_valid_in)
        begin
          txn_d  = in_txn_in;
          attr_d = rp_attr_pkg::ATTR_INIT;
          peer_d = 1'b0;
          val_d  = 1'b0;
          if (in_txn_in.io)
          begin
            txn_d.addr = io_win_base_in + in_txn_in.addr;
          end
          state_d = S_CHECK;
        end
      end
      S_CHECK:
      begin
        if (acs_ctl_in.v && ((txn_q.rid[15:8] < sec_bus_in) || (txn_q.rid[15:8] > sub_bus_in)))
        begin
          err_c = rp_attr_pkg::ERR_SRC;
        end
        else if (peer_hit && !p2p_en_in)
        begin
          err_c = rp_attr_pkg::ERR_NO_P2P;
        end
        else if (txn_q.translated && peer_hit && acs_ctl_in.t && ats_en_in && peer_rp_en_in)
        begin
          peer_d  = 1'b1;
          state_d = S_OVR;
        end
        else if (txn_q.translated && acs_ctl_in.b)
        begin
          err_c = rp_attr_pkg::ERR_XLAT_BLK;
        end
        else if (txn_q.cpl)
        begin
          peer_d  = peer_hit && !acs_ctl_in.c;
          state_d = S_OVR;
        end
        else if (redirect && !xlat_present_in)
        begin
          err_c = rp_attr_pkg::ERR_PERM;
        end
        else if (redirect || (xlat_present_in && !xlat_bypass_in && !txn_q.translated))
        begin
          val_d   = redirect;
          state_d = S_XREQ;
        end
        else
        begin
          peer_d  = peer_hit && !acs_ctl_in.u;
          state_d = S_OVR;
        end
        if (err_c != rp_attr_pkg::ERR_NONE)
        begin
          err_v   = 1'b1;
          drop_d  = 1'b1;
          state_d = S_IDLE;
        end
      end
      S_XREQ:
      begin
        if (xq_ready_in)
        begin
          state_d = S_XWAIT;
        end
      end
      S_XWAIT:
      begin
        if (xr_valid_in)
        begin
          if (val_q && !xr_in.perm_ok)
          begin
            err_v   = 1'b1;
            err_c   = rp_attr_pkg::ERR_PERM;
            drop_d  = 1'b1;
            state_d = S_IDLE;
          end
          else
          begin
            attr_d     = xr_in.attr;
            txn_d.addr = xr_in.pa;
            peer_d     = val_q && peer_rp_en_in;
            state_d    = S_OVR;
          end
        end
      end
      S_OVR:
      begin
        msi_d = msi_hit && txn_q.write;
        if (msi_hit && txn_q.write)
        begin
          attr_d = rp_attr_pkg::ATTR_DEV;
        end
        else if (peer_hit)
        begin
          attr_d = rp_attr_pkg::ATTR_DEV;
        end
        else if (spec_hit)
        begin
          attr_d = spec_attr_in;
        end
        else if (!io_coherent_in && attr_q.normal &&
                 ((attr_q.inner != rp_attr_pkg::CACHE_NC) || (attr_q.outer != rp_attr_pkg::CACHE_NC)))
        begin
          // Caches beyond the processing_element domain could hold data software cannot maintain.
          attr_d = rp_attr_pkg::ATTR_NC;
        end
        state_d = (msi_hit && txn_q.write) ? S_DRAIN : S_ISSUE;
      end
      S_DRAIN:
      begin
        if (cnt_q == rp_attr_pkg::CNT_ZERO)
        begin
          state_d = S_ISSUE;
        end
      end
      S_ISSUE:
      begin
        if (up_fire || peer_fire)
        begin
          state_d = S_IDLE;
        end
      end
      default:
      begin
        state_d = S_IDLE;
      end
    endcase
  end

  // ***********************************************************************
  // Posted write tracking
  // ***********************************************************************

  assign up_fire   = up_valid_out && up_ready_in;
  assign peer_fire = peer_valid_out && peer_ready_in;
  // Counting stalls new issue at saturation so no acknowledgement is lost.
  assign inc = up_fire && txn_q.write && !txn_q.cpl;
  assign dec = wr_ack_in && (cnt_q != rp_attr_pkg::CNT_ZERO);

  always_comb
  begin
    cnt_d = cnt_q;
    if (inc && !dec)
    begin
      cnt_d = cnt_q + 8'h01;
    end
    else if (dec && !inc)
    begin
      cnt_d = cnt_q - 8'h01;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      state_q <= S_IDLE;
      txn_q   <= '0;
      attr_q  <= rp_attr_pkg::ATTR_INIT;
      peer_q  <= 1'b0;
      val_q   <= 1'b0;
      msi_q   <= 1'b0;
      drop_q  <= 1'b0;
      cnt_q   <= rp_attr_pkg::CNT_ZERO;
    end
    else
    begin
      state_q <= state_d;
      txn_q   <= txn_d;
      attr_q  <= attr_d;
      peer_q  <= peer_d;
      val_q   <= val_d;
      msi_q   <= msi_d;
      drop_q  <= drop_d;
      cnt_q   <= cnt_d;
    end
  end

  // ***********************************************************************
  // Outputs
  // ***********************************************************************

  assign in_ready_out   = (state_q == S_IDLE);
  assign xq_valid_out   = (state_q == S_XREQ);
  assign xq_out         = '{addr: txn_q.addr, rid: txn_q.rid, attr: attr_q};
  // Issue only once attributes are final; one transaction in flight keeps order.
  assign up_valid_out   = (state_q == S_ISSUE) && !peer_q &&
                          (cnt_q != rp_attr_pkg::CNT_MAX);
  assign peer_valid_out = (state_q == S_ISSUE) && peer_q;
  assign up_out         = '{txn: txn_q, attr: attr_q};
  assign peer_out       = '{txn: txn_q, attr: attr_q};
  assign drop_out       = drop_q;

  assign err_hdr = '{code: err_c, rid: txn_q.rid, addr: txn_q.addr};

  acs_log u_log
  (
    .mclk_in    (mclk_in),
    .rst_b_in   (rst_b_in),
    .ev_in      (err_v),
    .ev_hdr_in  (err_hdr),
    .clr_in     (err_clr_in),
    .status_out (err_status_out),
    .hdr_out    (err_hdr_out),
    .report_out (err_report_out)
  );

endmodule

// ==== testbench/rp_attr_acs_properties.sv ====
// Checker for the root port attribute stage; sees the top module's ports only.
// Assumes one clock and a synchronous active-low reset; bound at the foot of this file.
`timescale 1ns/1ns
module rp_attr_acs_checker
(
  // Clock and reset
  input wire logic               mclk_in,
  input wire logic               rst_b_in,
  // Handshakes
  input wire logic               in_valid_in,
  input wire logic               in_ready_out,
  input wire logic               xq_valid_out,
  input wire rp_attr_pkg::xreq_s xq_out,
  input wire logic               xq_ready_in,
  input wire logic               up_valid_out,
  input wire rp_attr_pkg::out_s  up_out,
  input wire logic               up_ready_in,
  input wire logic               wr_ack_in,
  // Configuration
  input wire logic               io_coherent_in,
  input wire logic [47:0]        msi_base_in,
  input wire logic [47:0]        msi_limit_in,
  input wire logic [47:0]        spec_base_in,
  input wire logic [47:0]        spec_limit_in,
  // Reporting
  input wire logic               drop_out,
  input wire logic               err_status_out,
  input wire logic               err_report_out
);
  // ****
  // Outstanding upstream writes, kept here so interrupt ordering is judged independently.
  // ****
  logic [7:0] pend_q;
  logic [7:0] pend_d;
  logic       msi_hit;
  logic       spec_hit;
  assign msi_hit  = up_out.txn.write && up_out.txn.addr >= msi_base_in && up_out.txn.addr <= msi_limit_in;
  assign spec_hit = up_out.txn.addr >= spec_base_in && up_out.txn.addr <= spec_limit_in;
  always_comb
  begin
    pend_d = pend_q;
    if (up_valid_out && up_ready_in && up_out.txn.write && !up_out.txn.cpl)
      pend_d = pend_d + 8'h01;
    if (wr_ack_in)
      pend_d = pend_d - 8'h01;
  end
  always_ff @(posedge mclk_in)
    pend_q <= rst_b_in ? pend_d : 8'h00;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  a_take_once: assert property (in_valid_in && in_ready_out |=> !in_ready_out)
    else $error("request accepted while busy");
  a_query_attr: assert property (xq_valid_out |-> xq_out.attr == rp_attr_pkg::ATTR_INIT)
    else $error("query attributes not the initial ones");
  a_query_hold: assert property (xq_valid_out && !xq_ready_in |=> xq_valid_out && $stable(xq_out))
    else $error("query dropped or changed while stalled");
  a_up_hold: assert property (up_valid_out && !up_ready_in |=> up_valid_out && $stable(up_out))
    else $error("upstream request changed while stalled");
  a_msi_attr: assert property (up_valid_out && msi_hit |-> up_out.attr == rp_attr_pkg::ATTR_DEV)
    else $error("interrupt write may merge or allocate");
  a_msi_order: assert property (up_valid_out && msi_hit |-> pend_q == 8'h00)
    else $error("interrupt write passed earlier writes");
  a_noncoh_attr: assert property (up_valid_out && !io_coherent_in && !spec_hit |->
    up_out.attr.inner == rp_attr_pkg::CACHE_NC && up_out.attr.outer == rp_attr_pkg::CACHE_NC)
    else $error("cacheable attributes without coherency");
  a_report_drop: assert property (err_report_out |-> drop_out && err_status_out)
    else $error("violation report without drop or status");
  a_drop_pulse: assert property (drop_out |=> !drop_out)
    else $error("drop pulse longer than one cycle");
endmodule

bind pcie_root_port_attr_acs rp_attr_acs_checker u_props (.mclk_in, .rst_b_in, .in_valid_in, .in_ready_out,
  .xq_valid_out, .xq_out, .xq_ready_in, .up_valid_out, .up_out, .up_ready_in, .wr_ack_in, .io_coherent_in,
  .msi_base_in, .msi_limit_in, .spec_base_in, .spec_limit_in, .drop_out, .err_status_out, .err_report_out);

// ==== testbench/xlat_model.sv ====
// Behavioural translation unit answering one query at a time.
// Assumes the bench sets the answer and the wait before each request.
`timescale 1ns/1ns
module xlat_model
(
  // Clock and reset
  input wire logic               mclk_in,
  input wire logic               rst_b_in,
  // Control
  input wire rp_attr_pkg::xrsp_s rsp_in,
  input wire logic [3:0]         wait_in,
  // Query and answer
  input wire logic               xq_valid_in,
  output logic                   xq_ready_out,
  output logic                   xr_valid_out,
  output rp_attr_pkg::xrsp_s     xr_out
);
  logic [3:0] cnt_q;
  logic       pend_q;
  assign xq_ready_out = xq_valid_in && !pend_q && cnt_q == wait_in;
  // Outside the answer pulse the data toggles, so a stale value is never mistaken for an answer.
  always @(posedge mclk_in)
  begin
    xr_valid_out <= 1'h0;
    xr_out <= ~xr_out;
    if (!rst_b_in)
    begin
      cnt_q <= 4'h0;
      pend_q <= 1'h0;
      xr_out <= ~rsp_in;
    end
    else if (pend_q && cnt_q == wait_in)
    begin
      xr_valid_out <= 1'h1;
      xr_out <= rsp_in;
      pend_q <= 1'h0;
      cnt_q <= 4'h0;
    end
    else if (pend_q || xq_valid_in)
    begin
      pend_q <= pend_q || xq_ready_out;
      cnt_q <= xq_ready_out ? 4'h0 : cnt_q + 4'h1;
    end
  end
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the root port attribute and access-control stage.
// Assumes the translation unit model beside the design and the checker bound onto it.
`timescale 1ns/1ns
module tb;
  localparam logic [47:0] MSI_A = 48'h0000_1000_0000;
  localparam logic [47:0] PEER_A = 48'h0000_2000_0000;
  localparam logic [47:0] SPEC_A = 48'h0000_3000_0000;
  localparam logic [47:0] IO_B = 48'h0000_4000_0000;
  localparam logic [47:0] PLAIN = 48'h0000_5000_0000;
  localparam logic [47:0] PA = 48'h0000_6000_0000;
  localparam rp_attr_pkg::attr_s XATTR = 9'h188;
  logic mclk_in = 1'h0, rst_b_in = 1'h0, in_valid_in = 1'h0, err_clr_in = 1'h0;
  logic xlat_present_in = 1'h0, xlat_bypass_in = 1'h0, up_ready_in = 1'h0, wr_ack_in = 1'h0;
  logic peer_ready_in = 1'h0, p2p_en_in = 1'h1, peer_rp_en_in = 1'h0, ats_en_in = 1'h0;
  logic io_coherent_in = 1'h1;
  logic [7:0] sec_bus_in = 8'h01, sub_bus_in = 8'h04;
  logic [47:0] io_win_base_in = IO_B, msi_base_in = MSI_A, msi_limit_in = MSI_A + 48'hfff;
  logic [47:0] peer_base_in = PEER_A, peer_limit_in = PEER_A + 48'hfff_ffff;
  logic [47:0] spec_base_in = SPEC_A, spec_limit_in = SPEC_A + 48'hfff;
  rp_attr_pkg::attr_s spec_attr_in = 9'h054;
  rp_attr_pkg::acs_ctl_s acs_ctl_in = '0;
  rp_attr_pkg::txn_s in_txn_in = '0;
  rp_attr_pkg::xrsp_s xr_in, rsp = '0;
  rp_attr_pkg::xreq_s xq_out;
  rp_attr_pkg::out_s up_out, peer_out;
  rp_attr_pkg::err_s err_hdr_out;
  logic in_ready_out, xq_valid_out, xq_ready_in, xr_valid_in, up_valid_out, peer_valid_out;
  logic drop_out, err_status_out, err_report_out;
  logic [3:0] xwait = 4'h0;
  int bad_count = 0, checks = 0, cyc = 0;

  pcie_root_port_attr_acs DUT (.mclk_in, .rst_b_in, .in_valid_in, .in_txn_in, .in_ready_out,
    .xlat_present_in, .xlat_bypass_in, .xq_valid_out, .xq_out, .xq_ready_in, .xr_valid_in, .xr_in,
    .acs_ctl_in, .p2p_en_in, .peer_rp_en_in, .ats_en_in, .io_coherent_in, .sec_bus_in, .sub_bus_in,
    .io_win_base_in, .msi_base_in, .msi_limit_in, .peer_base_in, .peer_limit_in, .spec_base_in,
    .spec_limit_in, .spec_attr_in, .up_valid_out, .up_out, .up_ready_in, .wr_ack_in, .peer_valid_out,
    .peer_out, .peer_ready_in, .drop_out, .err_clr_in, .err_status_out, .err_hdr_out, .err_report_out);
  xlat_model u_xlat (.mclk_in, .rst_b_in, .rsp_in(rsp), .wait_in(xwait), .xq_valid_in(xq_valid_out),
    .xq_ready_out(xq_ready_in), .xr_valid_out(xr_valid_in), .xr_out(xr_in));

  always #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic send(input logic [47:0] a, input logic w, io, tr, input logic [15:0] rid);
    in_valid_in <= 1'h1;
    in_txn_in <= '{addr:a, rid:rid, tag:8'h5a, write:w, cpl:1'h0, io:io, translated:tr};
    do @(posedge mclk_in); while (!in_ready_out);
    in_valid_in <= 1'h0;
  endtask
  task automatic get_out(input logic p, input logic [47:0] a, input rp_attr_pkg::attr_s at);
    int n = 0;
    while (!(p ? peer_valid_out : up_valid_out) && n < 30)
    begin
      @(posedge mclk_in);
      n++;
    end
    chk("out_valid", p ? peer_valid_out : up_valid_out, 1'h1);
    chk("out_addr", p ? peer_out.txn.addr : up_out.txn.addr, a);
    chk("out_attr", p ? peer_out.attr : up_out.attr, at);
    peer_ready_in <= p;
    up_ready_in <= !p;
    @(posedge mclk_in);
    peer_ready_in <= 1'h0;
    up_ready_in <= 1'h0;
  endtask
  task automatic get_drop(input rp_attr_pkg::acs_err_e c);
    int n = 0;
    while (!err_report_out && n < 30)
    begin
      @(posedge mclk_in);
      n++;
    end
    chk("drop", drop_out, 1'h1);
    chk("err_code", err_hdr_out.code, c);
    chk("leak", up_valid_out | peer_valid_out, 1'h0);
    err_clr_in <= 1'h1;
    @(posedge mclk_in);
    err_clr_in <= 1'h0;
    @(posedge mclk_in);
    chk("status_clr", err_status_out, 1'h0);
  endtask
  task automatic ack();
    wr_ack_in <= 1'h1;
    @(posedge mclk_in);
    wr_ack_in <= 1'h0;
  endtask

  task automatic t_plain();
    send(PLAIN, 1'h0, 1'h0, 1'h0, 16'h0100);
    get_out(1'h0, PLAIN, rp_attr_pkg::ATTR_INIT);
    send(SPEC_A + 48'h10, 1'h0, 1'h0, 1'h0, 16'h0100);
    get_out(1'h0, SPEC_A + 48'h10, 9'h054);
    send(48'h80, 1'h0, 1'h1, 1'h0, 16'h0100);
    get_out(1'h0, IO_B + 48'h80, rp_attr_pkg::ATTR_INIT);
    io_coherent_in <= 1'h0;
    send(PLAIN, 1'h0, 1'h0, 1'h0, 16'h0100);
    get_out(1'h0, PLAIN, rp_attr_pkg::ATTR_NC);
    io_coherent_in <= 1'h1;
  endtask
  task automatic t_msi();
    send(PLAIN, 1'h1, 1'h0, 1'h0, 16'h0100);
    get_out(1'h0, PLAIN, rp_attr_pkg::ATTR_INIT);
    send(MSI_A + 48'h40, 1'h1, 1'h0, 1'h0, 16'h0100);
    repeat (8) @(posedge mclk_in);
    chk("msi_held", up_valid_out, 1'h0);
    ack();
    get_out(1'h0, MSI_A + 48'h40, rp_attr_pkg::ATTR_DEV);
    ack();
  endtask
  task automatic t_xlat();
    xlat_present_in <= 1'h1;
    xwait <= 4'h3;
    rsp <= '{pa:PA, attr:XATTR, perm_ok:1'h1};
    send(PLAIN, 1'h0, 1'h0, 1'h0, 16'h0100);
    get_out(1'h0, PA, XATTR);
    xlat_present_in <= 1'h0;
  endtask
  task automatic t_acs();
    acs_ctl_in <= '{v:1'h1, default:1'h0};
    send(PLAIN, 1'h0, 1'h0, 1'h0, 16'h0900);
    get_drop(rp_attr_pkg::ERR_SRC);
    acs_ctl_in <= '{b:1'h1, default:1'h0};
    send(PLAIN, 1'h0, 1'h0, 1'h1, 16'h0100);
    get_drop(rp_attr_pkg::ERR_XLAT_BLK);
    acs_ctl_in <= '0;
    p2p_en_in <= 1'h0;
    send(PEER_A, 1'h0, 1'h0, 1'h0, 16'h0100);
    get_drop(rp_attr_pkg::ERR_NO_P2P);
    send(PLAIN, 1'h0, 1'h0, 1'h0, 16'h0100);
    get_out(1'h0, PLAIN, rp_attr_pkg::ATTR_INIT);
    p2p_en_in <= 1'h1;
  endtask
  task automatic t_redir();
    acs_ctl_in <= '{r:1'h1, default:1'h0};
    xlat_present_in <= 1'h1;
    rsp <= '{pa:PEER_A + 48'h100, attr:XATTR, perm_ok:1'h0};
    send(PEER_A + 48'h200, 1'h0, 1'h0, 1'h0, 16'h0100);
    get_drop(rp_attr_pkg::ERR_PERM);
    rsp.perm_ok <= 1'h1;
    peer_rp_en_in <= 1'h1;
    send(PEER_A + 48'h200, 1'h0, 1'h0, 1'h0, 16'h0100);
    get_out(1'h1, PEER_A + 48'h100, rp_attr_pkg::ATTR_DEV);
    acs_ctl_in <= '0;
    xlat_present_in <= 1'h0;
    peer_rp_en_in <= 1'h0;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge mclk_in);
    rst_b_in <= 1'h1;
    @(posedge mclk_in);
    t_plain();
    t_msi();
    t_xlat();
    t_acs();
    t_redir();
    end_sim();
  end
endmodule
